// >>> hdl/cal_pkg.sv
// Overview of operation
// - Shift voltage samples later or earlier
// - Shift equals (trim minus 0x0D) times eight, a negative trim counting as zero
// - Positive difference delays, negative advances
// - Trim of 0x0D gives no shift
// - Phase trim read as two's complement
// - Range covers small leads and lags
// - Square every voltage and current sample
// - Low-pass squares, then square root
// - Voltage trim added after smoothing filter
// - Voltage trim twelve bits, signed
// - Current trim times 32768 before root
// - Interrupt can flag voltage zero crossings
package cal_pkg;

  // Register byte offsets
  localparam logic [7:0] PHASE_TRIM_ADDR = 8'h00;
  localparam logic [7:0] VOS_ADDR = 8'h04;
  localparam logic [7:0] IOS_ADDR = 8'h08;
  localparam logic [7:0] VOLTAGE_RMS_VALUE_ADDR = 8'h0C;
  localparam logic [7:0] CURRENT_RMS_VALUE_ADDR = 8'h10;
  localparam logic [7:0] IRQ_STAT_ADDR = 8'h14;
  localparam logic [7:0] IRQ_CLR_ADDR = 8'h18;
  localparam logic [7:0] IRQ_EN_ADDR = 8'h1C;

  // Phase trim value that gives no relative shift
  localparam int PHASE_NULL = 32'h0000_000D;
  // Eight clocks per trim step, as a shift
  localparam int PHASE_STEP_LOG2 = 32'h0000_0003;
  // Current offset trim scale of 32768, as a shift
  localparam int CUR_OS_SHIFT = 32'h0000_000F;

  // Interrupt layout
  localparam int IRQ_W = 32'h0000_0002;
  localparam int IRQ_ZX = 32'h0000_0000;
  localparam int IRQ_RMS = 32'h0000_0001;

  // One register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_type;

endpackage : cal_pkg

// >>> hdl/phase_rms_trim.sv
`timescale 1ns/10ps
module phase_rms_trim #(
  parameter int SAMPLE_W = 16,
  parameter int PT_W = 7,
  parameter int VOS_W = 12,
  parameter int IOS_W = 12,
  parameter int LPF_K = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire cal_pkg::bus_req_type bus_req,
  output logic [31:0] rd_data,
  // Sample stream, one pair per clock
  input wire logic signed [SAMPLE_W-1:0] v_sample,
  input wire logic signed [SAMPLE_W-1:0] i_sample,
  // Aligned samples
  output logic signed [SAMPLE_W-1:0] v_aligned,
  output logic signed [SAMPLE_W-1:0] i_aligned,
  // Results
  output logic [SAMPLE_W-1:0] voltage_rms_value,
  output logic [SAMPLE_W-1:0] current_rms_value,
  output logic irq
);
  import cal_pkg::*;

  // Ring address width: largest trim times eight fits
  localparam int AW = PT_W + PHASE_STEP_LOG2;
  localparam int DEPTH = 2 ** AW;
  localparam int SQ_W = 2 * SAMPLE_W;
  localparam int LW = SQ_W + LPF_K;
  localparam int RW = SQ_W + 2;
  localparam int VW = SAMPLE_W + 2;
  localparam int CW = $clog2(SAMPLE_W + 1);
  // Current channel sits at the null trim delay
  localparam logic [AW-1:0] CUR_DLY =
    AW'(PHASE_NULL << PHASE_STEP_LOG2);
  localparam logic signed [PT_W-1:0] PT_RST = PT_W'(PHASE_NULL);

  // One square-root engine
  typedef struct packed {
    logic [SQ_W-1:0] rad;
    logic [SAMPLE_W+3:0] rem;
    logic [SAMPLE_W-1:0] root;
  } sqrt_type;

  // Block state apart from the sample ring
  typedef struct packed {
    logic [AW-1:0] wp;
    logic primed;
    logic signed [SAMPLE_W-1:0] v_al;
    logic signed [SAMPLE_W-1:0] i_al;
    logic [SQ_W-1:0] v_sq;
    logic [SQ_W-1:0] i_sq;
    logic [LW-1:0] v_acc;
    logic [LW-1:0] i_acc;
    logic [CW-1:0] cnt;
    sqrt_type v_sr;
    sqrt_type i_sr;
    logic upd;
    logic [SAMPLE_W-1:0] v_rms;
    logic [SAMPLE_W-1:0] i_rms;
    logic signed [PT_W-1:0] phase_trim;
    logic signed [VOS_W-1:0] vos;
    logic signed [IOS_W-1:0] ios;
    logic [IRQ_W-1:0] irq_en;
    logic [IRQ_W-1:0] irq_stat;
    logic irq;
    logic [31:0] rd_data;
  } state_type;

  state_type s_reg; // Registered state
  state_type s_next; // Next state

  // Sample history; too deep for the state struct
  logic [2*SAMPLE_W-1:0] ring_mem [DEPTH];

  // One bit-pair step of the restoring square root
  function automatic sqrt_type sqrt_step(input sqrt_type s);
    sqrt_type n;
    logic [SAMPLE_W+3:0] trial;
    n = s;
    n.rem = {s.rem[SAMPLE_W+1:0], s.rad[SQ_W-1 -: 2]};
    n.rad = {s.rad[SQ_W-3:0], 2'h0};
    trial = {2'h0, s.root, 2'h1};
    if (n.rem >= trial) begin
      n.rem = n.rem - trial;
      n.root = {s.root[SAMPLE_W-2:0], 1'h1};
    end else begin
      n.root = {s.root[SAMPLE_W-2:0], 1'h0};
    end
    return n;
  endfunction : sqrt_step

  // Combinational helpers
  logic [AW-1:0] v_dly; // Voltage read depth
  logic [AW-1:0] v_idx; // Voltage read index
  logic [AW-1:0] i_idx; // Current read index
  logic [2*SAMPLE_W-1:0] v_word; // Voltage ring word
  logic [2*SAMPLE_W-1:0] i_word; // Current ring word
  logic signed [SQ_W-1:0] v_ext; // Sign-extended voltage
  logic signed [SQ_W-1:0] i_ext; // Sign-extended current
  logic signed [RW-1:0] i_sum; // Current mean plus trim
  logic signed [VW-1:0] v_sum; // Voltage root plus trim
  logic [SQ_W-1:0] i_rad; // Clamped current radicand
  logic [IRQ_W-1:0] irq_clr; // Write-one-to-clear mask
  logic [IRQ_W-1:0] irq_ev; // Events of this cycle

  // Ring write; every clock stores the newest pair
  always_ff @(posedge clk) begin
    ring_mem[s_reg.wp] <= {v_sample, i_sample};
  end

  // Next-state logic
  always_comb begin
    s_next = s_reg;
    irq_clr = '0;
    irq_ev = '0;

    // Ring pointer; primed once every entry holds data
    s_next.wp = s_reg.wp + AW'(1);
    if (s_reg.wp == '1) begin
      s_next.primed = 1'h1;
    end

    // Negative trims clamp at zero depth: the most
    // advance is the current channel's own delay
    if (s_reg.phase_trim[PT_W-1]) begin
      v_dly = '0;
    end else begin
      v_dly = AW'(s_reg.phase_trim) << PHASE_STEP_LOG2;
    end

    // Voltage depth against fixed current depth
    v_idx = s_reg.wp - AW'(1) - v_dly;
    i_idx = s_reg.wp - AW'(1) - CUR_DLY;
    // Unwritten words read as zero: an unknown would stick in the filters
    if (s_reg.primed || s_reg.wp == '1) begin
      v_word = ring_mem[v_idx];
      i_word = ring_mem[i_idx];
    end else begin
      v_word = '0;
      i_word = '0;
    end
    s_next.v_al = v_word[2*SAMPLE_W-1:SAMPLE_W];
    s_next.i_al = i_word[SAMPLE_W-1:0];

    // Squares; the result is never negative
    v_ext = SQ_W'(s_reg.v_al);
    i_ext = SQ_W'(s_reg.i_al);
    s_next.v_sq = v_ext * v_ext;
    s_next.i_sq = i_ext * i_ext;

    // First-order low-pass; the mean sits above LPF_K
    s_next.v_acc = s_reg.v_acc + LW'(s_reg.v_sq)
      - (s_reg.v_acc >> LPF_K);
    s_next.i_acc = s_reg.i_acc + LW'(s_reg.i_sq)
      - (s_reg.i_acc >> LPF_K);

    // Current trim joins the mean square before the root
    i_sum = signed'({2'h0, s_reg.i_acc[LW-1:LPF_K]})
      + (RW'(s_reg.ios) <<< CUR_OS_SHIFT);
    if (i_sum[RW-1]) begin
      i_rad = '0;
    end else if (i_sum[RW-2:SQ_W] != '0) begin
      i_rad = '1;
    end else begin
      i_rad = i_sum[SQ_W-1:0];
    end

    // Root engines: load, then one step per clock
    s_next.upd = 1'h0;
    v_sum = '0;
    if (s_reg.cnt == '0) begin
      s_next.v_sr = '0;
      s_next.v_sr.rad = s_reg.v_acc[LW-1:LPF_K];
      s_next.i_sr = '0;
      s_next.i_sr.rad = i_rad;
      s_next.cnt = CW'(1);
    end else begin
      s_next.v_sr = sqrt_step(s_reg.v_sr);
      s_next.i_sr = sqrt_step(s_reg.i_sr);
      if (s_reg.cnt == CW'(SAMPLE_W)) begin
        // Last step: publish both results
        s_next.cnt = '0;
        s_next.upd = 1'h1;
        v_sum = signed'({2'h0, s_next.v_sr.root})
          + VW'(s_reg.vos);
        if (v_sum[VW-1]) begin
          s_next.v_rms = '0;
        end else if (v_sum[VW-2]) begin
          s_next.v_rms = '1;
        end else begin
          s_next.v_rms = v_sum[SAMPLE_W-1:0];
        end
        s_next.i_rms = s_next.i_sr.root;
      end else begin
        s_next.cnt = s_reg.cnt + CW'(1);
      end
    end

    // Register writes
    if (bus_req.wr) begin
      case (bus_req.addr)
        PHASE_TRIM_ADDR: begin
          s_next.phase_trim = bus_req.wdata[PT_W-1:0];
        end
        VOS_ADDR: begin
          s_next.vos = bus_req.wdata[VOS_W-1:0];
        end
        IOS_ADDR: begin
          s_next.ios = bus_req.wdata[IOS_W-1:0];
        end
        IRQ_CLR_ADDR: begin
          irq_clr = bus_req.wdata[IRQ_W-1:0];
        end
        IRQ_EN_ADDR: begin
          s_next.irq_en = bus_req.wdata[IRQ_W-1:0];
        end
        default: begin
          // Read-only or unmapped: ignored
        end
      endcase
    end

    // Voltage zero crossing is a sign change
    irq_ev[IRQ_ZX] = s_reg.primed
      && (s_next.v_al[SAMPLE_W-1] != s_reg.v_al[SAMPLE_W-1]);
    irq_ev[IRQ_RMS] = s_next.upd;

    // Set wins over a clear in the same cycle
    s_next.irq_stat = (s_reg.irq_stat & ~irq_clr) | irq_ev;
    s_next.irq = |(s_next.irq_stat & s_next.irq_en);

    // Register reads; data only in the following cycle
    s_next.rd_data = '0;
    if (bus_req.rd) begin
      case (bus_req.addr)
        PHASE_TRIM_ADDR: begin
          s_next.rd_data = 32'($unsigned(s_reg.phase_trim));
        end
        VOS_ADDR: begin
          s_next.rd_data = 32'($unsigned(s_reg.vos));
        end
        IOS_ADDR: begin
          s_next.rd_data = 32'($unsigned(s_reg.ios));
        end
        VOLTAGE_RMS_VALUE_ADDR: begin
          s_next.rd_data = 32'(s_reg.v_rms);
        end
        CURRENT_RMS_VALUE_ADDR: begin
          s_next.rd_data = 32'(s_reg.i_rms);
        end
        IRQ_STAT_ADDR: begin
          s_next.rd_data = 32'(s_reg.irq_stat);
        end
        IRQ_EN_ADDR: begin
          s_next.rd_data = 32'(s_reg.irq_en);
        end
        default: begin
          // Unmapped and write-only read as zero
          s_next.rd_data = '0;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.phase_trim <= PT_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from state flops
  assign rd_data = s_reg.rd_data;
  assign v_aligned = s_reg.v_al;
  assign i_aligned = s_reg.i_al;
  assign voltage_rms_value = s_reg.v_rms;
  assign current_rms_value = s_reg.i_rms;
  assign irq = s_reg.irq;

  // Null trim keeps the channels in step
  null_trim_a: assert property (
    @(posedge clk) disable iff (rst)
    (s_reg.primed && $past(s_reg.phase_trim) == 13)
      |-> (v_aligned == $past(v_sample, 106)))
    else $error("null trim does not match current delay");

  // Fixed current path depth
  cur_delay_a: assert property (
    @(posedge clk) disable iff (rst)
    s_reg.primed |-> (i_aligned == $past(i_sample, 106)))
    else $error("current channel delay wrong");

  // One step above null delays by eight clocks
  delay_step_a: assert property (
    @(posedge clk) disable iff (rst)
    (s_reg.primed && $past(s_reg.phase_trim) == 14)
      |-> (v_aligned == $past(v_sample, 114)))
    else $error("voltage not delayed by one step");

  // One step below null advances by eight clocks
  advance_step_a: assert property (
    @(posedge clk) disable iff (rst)
    (s_reg.primed && $past(s_reg.phase_trim) == 12)
      |-> (v_aligned == $past(v_sample, 98)))
    else $error("voltage not advanced by one step");

  // Negative trim saturates at the largest advance
  neg_trim_a: assert property (
    @(posedge clk) disable iff (rst)
    (s_reg.primed && $past(s_reg.phase_trim) < 0)
      |-> (v_aligned == $past(v_sample, 2)))
    else $error("negative trim not read as signed");

  // Squares follow the aligned samples by one clock
  square_a: assert property (
    @(posedge clk) disable iff (rst)
    ##1 (s_reg.v_sq == SQ_W'($past(v_ext) * $past(v_ext))))
    else $error("voltage square wrong");

  // Clocks since the last result update, saturating
  logic [CW-1:0] upd_gap;
  logic upd_seen; // An update has been seen since reset
  always_ff @(posedge clk) begin
    if (rst) begin
      upd_gap <= '0;
      upd_seen <= 1'h0;
    end else if (s_reg.upd) begin
      upd_gap <= CW'(1);
      upd_seen <= 1'h1;
    end else if (upd_gap != '1) begin
      upd_gap <= upd_gap + CW'(1);
    end
  end

  // Results refresh every seventeen clocks
  rms_period_a: assert property (
    @(posedge clk) disable iff (rst)
    (s_reg.upd && upd_seen) |-> (upd_gap == CW'(SAMPLE_W + 1)))
    else $error("rms update period wrong");

  // Voltage trim adds to the finished root
  voltage_rms_value_trim_a: assert property (
    @(posedge clk) disable iff (rst)
    (s_reg.upd && $past(s_reg.vos) == 0 && $stable(s_reg.vos))
      |-> (voltage_rms_value == s_reg.v_sr.root))
    else $error("voltage rms offset path wrong");

  // Interrupt line tracks enabled status
  irq_level_a: assert property (
    @(posedge clk) disable iff (rst)
    ##1 (irq == |(s_reg.irq_stat & s_reg.irq_en)))
    else $error("interrupt level wrong");

  // Sign change latches the crossing flag
  zx_flag_a: assert property (
    @(posedge clk) disable iff (rst)
    irq_ev[IRQ_ZX] |=> s_reg.irq_stat[IRQ_ZX])
    else $error("zero crossing flag lost");

  // Read answers exactly one cycle later
  read_stat_a: assert property (
    @(posedge clk) disable iff (rst)
    (bus_req.rd && bus_req.addr == IRQ_STAT_ADDR)
      |=> (rd_data == 32'($past(s_reg.irq_stat))))
    else $error("status read data wrong");

endmodule : phase_rms_trim

// >>> sim/host_model.sv
`timescale 1ns/10ps
module host_model (
  // Clock
  input wire logic clk,
  // Register port
  output cal_pkg::bus_req_type bus_req,
  input wire logic [31:0] rd_data
);
  import cal_pkg::*;

  // Bus idle from time zero
  initial bus_req = '0;

  // One-cycle write strobe, never held over
  task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask : write_reg

  // Data stands only in the cycle after the strobe
  task automatic read_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1 d = rd_data;
  endtask : read_reg
endmodule : host_model

// >>> sim/phase_and_rms_offset_trim_bench.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  miscompares++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module phase_and_rms_offset_trim_bench;
  import cal_pkg::*;
  // Clock, reset and bus
  logic clk, rst;
  bus_req_type bus_req;
  logic [31:0] rd_data, d;
  // Sample stream; ramp makes shifts visible as a difference
  logic signed [15:0] v_sample, i_sample, v_aligned, i_aligned;
  logic signed [15:0] v_lvl, i_lvl;
  logic [15:0] voltage_rms_value, current_rms_value, cnt, diff;
  logic irq, ramp;
  int miscompares = 0, samples_checked = 0, cycles = 0, e;
  // Reset table: address and expected low byte
  logic [7:0] ra [6] = '{8'h00, 8'h04, 8'h08, 8'h1C, 8'h18, 8'h20};
  logic [7:0] rv [6] = '{8'h0D, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  // Trims: null, one step later, two earlier, top, minus one
  logic [6:0] tr [5] = '{7'h0D, 7'h0E, 7'h0B, 7'h3F, 7'h7F};

  phase_rms_trim phase_rms_trim_i (.clk(clk), .rst(rst), .bus_req(bus_req),
    .rd_data(rd_data), .v_sample(v_sample), .i_sample(i_sample),
    .v_aligned(v_aligned), .i_aligned(i_aligned),
    .voltage_rms_value(voltage_rms_value),
    .current_rms_value(current_rms_value), .irq(irq));
  host_model host_model_i (.clk(clk), .bus_req(bus_req), .rd_data(rd_data));

  // Time-zero values
  initial begin
    {cnt, v_sample, i_sample, v_lvl, i_lvl} = '0;
    ramp = 1'b0;
    rst = 1'b1;
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Samples change only at the rising edge
  always @(posedge clk) begin
    cnt <= cnt + 16'h0001;
    v_sample <= ramp ? cnt : v_lvl;
    i_sample <= ramp ? cnt : i_lvl;
  end

  // Hang guard, well above the planned run
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  // Ramp in both channels: lag of voltage minus lag of current
  task automatic check_phase(input logic [6:0] t);
    host_model_i.write_reg(PHASE_TRIM_ADDR, {25'h000_0000, t});
    repeat (600) @(posedge clk);
    #1 diff = i_aligned - v_aligned;
    // Negative trims stop at the largest advance
    e = ($signed(t) < 0) ? -104 : (int'($signed(t)) - 13) * 8;
    `CHK("phase shift", 16'(e), diff)
  endtask : check_phase

  // Bounded wait for the interrupt line
  task automatic wait_irq(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
      if (irq === 1'b1) break;
    end
  endtask : wait_irq

  task automatic rms_case(input logic [15:0] lv, ev, ei);
    v_lvl <= lv;
    i_lvl <= lv;
    repeat (6000) @(posedge clk);
    host_model_i.read_reg(VOLTAGE_RMS_VALUE_ADDR, d);
    `CHK("voltage rms", {16'h0000, ev}, d)
    `CHK("voltage rms pin", ev, voltage_rms_value)
    host_model_i.read_reg(CURRENT_RMS_VALUE_ADDR, d);
    `CHK("current rms", {16'h0000, ei}, d)
    `CHK("current rms pin", ei, current_rms_value)
  endtask : rms_case

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    // Reset values, write-only and unmapped places
    for (int k = 0; k < 6; k++) begin
      host_model_i.read_reg(ra[k], d);
      `CHK("reset value", {24'h00_0000, rv[k]}, d)
    end
    // Voltage trim keeps twelve raw bits
    host_model_i.write_reg(VOS_ADDR, 32'hFFFF_FFFF);
    host_model_i.read_reg(VOS_ADDR, d);
    `CHK("voltage trim width", 32'h0000_0FFF, d)
    host_model_i.write_reg(VOLTAGE_RMS_VALUE_ADDR, 32'h0000_1234);
    host_model_i.read_reg(VOLTAGE_RMS_VALUE_ADDR, d);
    `CHK("result read only", 32'h0000_0000, d)
    // Delay, advance and signed trims
    ramp <= 1'b1;
    foreach (tr[k]) check_phase(tr[k]);
    // Square, smooth, root, both trims; then clamp at zero
    ramp <= 1'b0;
    host_model_i.write_reg(VOS_ADDR, 32'h0000_0FFB);
    host_model_i.write_reg(IOS_ADDR, 32'h0000_0001);
    rms_case(16'h03E8, 16'h03E3, 16'h03F8);
    rms_case(16'h0000, 16'h0000, 16'h00B5);
    // Update interrupt enabled, then masked
    host_model_i.write_reg(IRQ_EN_ADDR, 32'h0000_0002);
    wait_irq(40);
    `CHK("update irq", 1'b1, irq)
    host_model_i.write_reg(IRQ_EN_ADDR, 32'h0000_0001);
    host_model_i.write_reg(IRQ_CLR_ADDR, 32'h0000_0003);
    repeat (2) @(posedge clk);
    #1 `CHK("masked irq", 1'b0, irq)
    // Voltage goes negative: zero crossing flagged
    v_lvl <= -16'sd1000;
    wait_irq(200);
    `CHK("crossing irq", 1'b1, irq)
    host_model_i.read_reg(IRQ_STAT_ADDR, d);
    `CHK("crossing status", 1'b1, d[IRQ_ZX])
    host_model_i.write_reg(IRQ_CLR_ADDR, 32'h0000_0001);
    host_model_i.read_reg(IRQ_STAT_ADDR, d);
    `CHK("crossing cleared", 1'b0, d[IRQ_ZX])
    `CHK("irq released", 1'b0, irq)
    tally_and_finish();
  end
endmodule : phase_and_rms_offset_trim_bench
